// *** core/pie_expander.sv ***
module pie_expander
	import pie_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// peripheral request pulses, bit 8*(g-1)+(s-1) is group g slot s
	input wire logic [95:0] periph_req,
	// core register port, 16-bit words
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// vector fetch by taken interrupt or vector call
	input wire logic fetch_req,
	input wire logic [3:0] fetch_group,
	input wire logic fetch_call,
	output logic [11:0] fetch_addr,
	output logic [3:0] fetch_slot,
	output logic fetch_valid,
	// interrupt lines to the core
	output logic [11:0] cpu_int
);
	import pie_pkg::*;

	// overview of the block, for whoever picks it up next:
	// - peripheral requests arrive from other parts of the chip with no
	//   known timing, so every request bit goes through two flops and an
	//   edge detector before it may set a flag
	// - a flag is set by a rising request edge or by a software write of
	//   the group flag word; a write replaces the whole byte, so a pending
	//   peripheral flag can be wiped by careless software
	// - a group line is high while the expander is enabled, the group is
	//   not waiting for its acknowledge, and some slot of the group has its
	//   flag and its enable set
	// - the core fetches a vector in one of two ways: a taken interrupt
	//   picks the lowest pending enabled slot, clears that flag and blocks
	//   the group; a vector call always picks slot one and leaves flags be
	// - a fetch is refused, with no valid pulse, for group zero, a group
	//   above twelve, or while the expander is disabled
	// - every output is a flop of the one state struct, so the core always
	//   sees settled values one cycle after its request
	// limitation: only one fetch per cycle; the core model never asks for
	// more, and a real core would not either
	// trade-off: all 96 slots live in one flat vector instead of twelve
	// small group modules; the indexing is a bit denser but the whole
	// state stays in one struct as the house idiom asks

	// whole block state
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic [95:0] req_meta; // first synchroniser stage
		logic [95:0] req_sync;
		logic [95:0] req_prev; // edge detect on synced request
		logic enabled; // expander enable from control register
		logic [95:0] ena;
		logic [95:0] flg;
		logic [11:0] ack; // set = group blocked until acked
		logic [15:0] rdata;
		logic [11:0] faddr;
		logic [3:0] fslot;
		logic fvalid;
		logic [11:0] line;
	} pie_state_type;

	pie_state_type st_r, st_nxt;
	logic [95:0] hw_mask; // slots wired to a peripheral
	logic [95:0] rise;

	// build the hardware source mask from the table
	always_comb begin
		for (int g = 0; g < GROUPS; g++) begin
			hw_mask[g*SLOTS +: SLOTS] = HW_MAP[g];
		end
	end

	// only wired slots can be set by a peripheral edge
	assign rise = st_r.req_sync & ~st_r.req_prev & hw_mask;

	// next-state logic
	always_comb begin
		logic [11:0] off;
		logic [3:0] gi;
		logic [7:0] pend;
		logic found;
		off = 12'h000;
		gi = 4'h0;
		pend = 8'h00;
		found = 1'b0;
		st_nxt = st_r;
		st_nxt.rst_meta = 1'b1;
		st_nxt.rst_sync = st_r.rst_meta;
		st_nxt.req_meta = periph_req;
		st_nxt.req_sync = st_r.req_meta;
		st_nxt.req_prev = st_r.req_sync;
		st_nxt.rdata = 16'h0000;
		st_nxt.fvalid = 1'b0;
		// register writes; software flag write replaces the byte
		if (reg_wr) begin
			if (reg_addr == CTRL_ADDR) begin
				st_nxt.enabled = reg_wdata[CTRL_ENA_BIT];
			end else if (reg_addr == ACK_ADDR) begin
				st_nxt.ack = st_r.ack & ~reg_wdata[11:0]; // write 1 releases
			end else if (reg_addr >= ENA_BASE && reg_addr < RSV_LO) begin
				off = reg_addr - ENA_BASE;
				gi = off[4:1];
				if (off[0] == 1'b0) begin
					st_nxt.ena[gi*SLOTS +: SLOTS] = reg_wdata[7:0];
				end else begin
					// reserved slots act as software interrupts
					st_nxt.flg[gi*SLOTS +: SLOTS] = reg_wdata[7:0];
				end
			end
		end
		// peripheral edges win over a simultaneous software clear
		st_nxt.flg = st_nxt.flg | rise;
		// register reads
		if (reg_rd) begin
			if (reg_addr == CTRL_ADDR) begin
				st_nxt.rdata = {15'h0000, st_r.enabled};
			end else if (reg_addr == ACK_ADDR) begin
				st_nxt.rdata = {4'h0, st_r.ack};
			end else if (reg_addr >= ENA_BASE && reg_addr < RSV_LO) begin
				off = reg_addr - ENA_BASE;
				gi = off[4:1];
				if (off[0] == 1'b0) begin
					st_nxt.rdata = {8'h00, st_r.ena[gi*SLOTS +: SLOTS]};
				end else begin
					st_nxt.rdata = {8'h00, st_r.flg[gi*SLOTS +: SLOTS]};
				end
			end
		end
		// vector fetch: lowest pending enabled slot, or slot 1 for a call
		if (fetch_req && fetch_group >= 4'h1 && fetch_group <= 4'hc
		    && st_r.enabled) begin
			gi = fetch_group - 4'h1;
			pend = st_r.flg[gi*SLOTS +: SLOTS] & st_r.ena[gi*SLOTS +: SLOTS];
			st_nxt.fslot = 4'h0;
			if (!fetch_call) begin
				for (int s = SLOTS - 1; s >= 0; s--) begin
					if (pend[s]) begin
						st_nxt.fslot = 4'(s);
						found = 1'b1;
					end
				end
			end
			// call always picks slot one
			st_nxt.faddr = VEC_BASE + 12'(gi) * GROUP_STEP
				+ 12'(st_nxt.fslot) * SLOT_STEP;
			st_nxt.fvalid = 1'b1;
			if (found) begin
				// taking the interrupt clears its flag and blocks the group
				st_nxt.flg[gi*SLOTS + st_nxt.fslot[2:0]] =
					rise[gi*SLOTS + st_nxt.fslot[2:0]];
				st_nxt.ack[gi] = 1'b1;
			end
		end
		// group lines
		// built from the next ack, flag and slot enable bits, so a taken interrupt drops its line
		// on the same edge and the core cannot take the group twice
		for (int g = 0; g < GROUPS; g++) begin
			st_nxt.line[g] = st_r.enabled && !st_nxt.ack[g]
				&& |(st_nxt.flg[g*SLOTS +: SLOTS] & st_nxt.ena[g*SLOTS +: SLOTS]);
		end
	end

	// registers; reset flops take constants only
	// the released reset first walks through rst_meta and rst_sync; until
	// it has, only those two bits move, so no request can be taken on a
	// half-released edge and no state changes from a metastable reset
	// the address register resets to the base of the table so that a
	// fetch output never shows a value outside the vector area
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.ena <= {GROUPS{ENA_RST}};
			st_r.flg <= {GROUPS{FLG_RST}};
			st_r.ack <= ACK_RST;
			st_r.faddr <= VEC_BASE;
		end else if (!st_r.rst_sync) begin
			// released reset still settling: hold control state
			st_r.rst_meta <= st_nxt.rst_meta;
			st_r.rst_sync <= st_nxt.rst_sync;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	// read data is zero whenever no read was taken, which lets the core
	// or together several read sources without a mux
	assign reg_rdata = st_r.rdata;
	assign fetch_addr = st_r.faddr;
	assign fetch_slot = st_r.fslot;
	assign fetch_valid = st_r.fvalid;
	assign cpu_int = st_r.line;
endmodule : pie_expander

// *** core/pie_pkg.sv ***
package pie_pkg;
	// group and slot geometry
	localparam int GROUPS = 12;
	localparam int SLOTS = 8;
	localparam int SOURCES = 96;
	// register word addresses (16-bit words)
	localparam logic [11:0] CTRL_ADDR = 12'hce0;
	localparam logic [11:0] ACK_ADDR = 12'hce1;
	localparam logic [11:0] ENA_BASE = 12'hce2;
	localparam logic [11:0] FLG_BASE = 12'hce3;
	localparam logic [11:0] RSV_LO = 12'hcfa;
	// vector table layout
	localparam logic [11:0] VEC_BASE = 12'hd40;
	localparam logic [11:0] VEC_LAST = 12'hdfe;
	localparam logic [11:0] SLOT_STEP = 12'h002;
	localparam logic [11:0] GROUP_STEP = 12'h010;
	// control field and reset values
	localparam int CTRL_ENA_BIT = 0;
	localparam logic [7:0] ENA_RST = 8'h00;
	localparam logic [7:0] FLG_RST = 8'h00;
	localparam logic [11:0] ACK_RST = 12'h000;
	// which slots have a hardware source, one byte per group, bit0 = slot 1
	localparam logic [7:0] HW_MAP [GROUPS] = '{
		8'hfb, 8'h7f, 8'h7f, 8'h01, 8'h01, 8'h0f,
		8'h00, 8'h03, 8'h3f, 8'hff, 8'hff, 8'hc1};
endpackage : pie_pkg

// *** sim/pie_checker.sv ***
module pie_checker (
	// watched ports
	input wire logic core_clk, resetn, reg_rd, fetch_req, fetch_call,
	input wire logic fetch_valid,
	input wire logic [11:0] reg_addr, fetch_addr, cpu_int,
	input wire logic [15:0] reg_rdata,
	input wire logic [3:0] fetch_group, fetch_slot
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_idle; !reg_rd |=> reg_rdata == 16'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata");
	property p_gap; reg_rd && reg_addr >= 12'hcfa |=> !reg_rdata; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_cause; fetch_valid |-> $past(fetch_req); endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_bad; fetch_req && (fetch_group == 4'h0 ||
		fetch_group > 4'hc) |=> !fetch_valid; endproperty
	a_bad: assert property (p_bad) else $error("group");
	property p_one; fetch_req && fetch_call |=> !fetch_slot; endproperty
	a_one: assert property (p_one) else $error("slot");
	property p_addr; fetch_valid |-> fetch_addr == 12'hd30 +
		{$past(fetch_group), 4'h0} + {fetch_slot, 1'b0}; endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_hold; !fetch_valid |-> $stable(fetch_addr); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	// a taken interrupt sets the ack, so the line drops at once
	property p_ack; fetch_valid && !$past(fetch_call) |->
		!cpu_int[$past(fetch_group) - 4'h1]; endproperty
	a_ack: assert property (p_ack) else $error("ack");
	cover property (fetch_valid && fetch_call);
	cover property (fetch_valid && !fetch_slot[3]);
	cover property ($rose(cpu_int[6]));
endmodule : pie_checker

// *** sim/pie_core_model.sv ***
module pie_core_model (
	input wire logic core_clk, take_en, call_req,
	input wire logic [3:0] call_num,
	input wire logic [11:0] cpu_int,
	output logic fetch_req = 1'b0,
	output logic [3:0] fetch_group = 4'h0,
	output logic fetch_call = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines toggle so a stale group is never mistaken for a request
	always @(posedge core_clk) begin
		fetch_req <= 1'b0;
		fetch_group <= ~fetch_group;
		fetch_call <= ~fetch_call;
		if (call_req && call_num != 4'h0) begin
			fetch_req <= 1'b1;
			fetch_call <= 1'b1;
			fetch_group <= call_num;
		end else if (take_en && !fetch_req && cpu_int != 12'h0) begin
			fetch_req <= 1'b1;
			fetch_call <= 1'b0;
			for (int g = 12; g >= 1; g--)
				if (cpu_int[g-1]) fetch_group <= 4'(g);
		end
	end
endmodule : pie_core_model

// *** sim/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
	logic take_en = 0, call_req = 0, fetch_req, fetch_call, fetch_valid;
	logic [95:0] periph_req = '0;
	logic [11:0] reg_addr = '0, fetch_addr, cpu_int;
	logic [15:0] reg_wdata = '0, reg_rdata;
	logic [3:0] call_num = 4'h1, fetch_group, fetch_slot;
	int err_count = 0, n_tests = 0;
	pie_expander dut (.core_clk, .resetn, .periph_req, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .fetch_req, .fetch_group,
		.fetch_call, .fetch_addr, .fetch_slot, .fetch_valid, .cpu_int);
	pie_core_model cpu (.core_clk, .take_en, .call_req, .call_num,
		.cpu_int, .fetch_req, .fetch_group, .fetch_call);
	initial forever #10 core_clk = ~core_clk;
	task chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// bounded wait for the vector answer, then judge it
	task wv(input logic [11:0] ea, input logic [3:0] es);
		repeat (12) begin
			@(posedge core_clk);
			#1 if (fetch_valid === 1'b1) break;
		end
		chk({15'h0, fetch_valid}, 16'h1);
		chk({4'h0, fetch_addr}, {4'h0, ea});
		chk({12'h0, fetch_slot}, {12'h0, es});
	endtask : wv
	task call(input logic [3:0] n);
		@(posedge core_clk);
		call_req <= 1'b1;
		call_num <= n;
		@(posedge core_clk);
		call_req <= 1'b0;
	endtask : call
	// empty group seven used as a software interrupt
	task t_soft;
		wr(12'hce0, 16'h1);
		wr(12'hcee, 16'h4);
		wr(12'hcef, 16'h4);
		@(posedge core_clk);
		#1 chk({15'h0, cpu_int[6]}, 16'h1);
		take_en <= 1'b1;
		wv(12'hda4, 4'h2);
		chk({15'h0, cpu_int[6]}, 16'h0);
		rd(12'hce1, 16'h40);
		rd(12'hce0, 16'h1);
		wr(12'hce1, 16'h40);
		rd(12'hcef, 16'h0);
	endtask : t_soft
	// timer source taken, unwired slot three ignored
	task t_hw;
		wr(12'hce2, 16'h44);
		periph_req <= 96'h44;
		wv(12'hd4c, 4'h6);
		periph_req <= '0;
		rd(12'hce3, 16'h0);
		wr(12'hce1, 16'h1);
	endtask : t_hw
	task t_call;
		for (int n = 1; n <= 12; n++) begin
			call(n[3:0]);
			wv(12'hd40 + 12'(16 * (n - 1)), 4'h0);
		end
		rd(12'hcfa, 16'h0);
		wr(12'hce0, 16'h0);
		call(4'h1);
		repeat (4) begin
			@(posedge core_clk);
			#1 chk({15'h0, fetch_valid}, 16'h0);
		end
	endtask : t_call
	task test_done;
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_soft;
		t_hw;
		t_call;
		test_done;
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		test_done;
	end
endmodule : tb
bind pie_expander pie_checker chk_i (.core_clk, .resetn, .reg_rd,
	.fetch_req, .fetch_call, .fetch_valid, .reg_addr, .fetch_addr,
	.cpu_int, .reg_rdata, .fetch_group, .fetch_slot);
